// ==== common/rht_cmd_pkg.sv ====
// package: constants and state records of the sensor command unit
package rht_cmd_pkg;
	localparam logic [6:0] DEV_ADDR      = 7'h40;
	localparam logic [7:0] CMD_HUM_HOLD  = 8'he5;
	localparam logic [7:0] CMD_HUM_POLL  = 8'hf5;
	localparam logic [7:0] CMD_TMP_HOLD  = 8'he3;
	localparam logic [7:0] CMD_TMP_POLL  = 8'hf3;
	localparam logic [7:0] CMD_PREV_TMP  = 8'he0;
	localparam logic [7:0] CMD_SOFT_RST  = 8'hfe;
	localparam logic [7:0] CMD_UREG_WR   = 8'he6;
	localparam logic [7:0] CMD_UREG_RD   = 8'he7;
	localparam logic [7:0] UREG_RESET    = 8'h3a;
	localparam logic [7:0] UREG_WMASK    = 8'h85;
	localparam int         UREG_HEAT_BIT = 2;
	localparam logic [7:0] CRC_POLY      = 8'h31;
	localparam logic [7:0] CRC_INIT      = 8'h00;
	localparam logic [1:0] HUM_TAIL      = 2'b10;
	localparam logic [1:0] TEMP_TAIL     = 2'b00;
	localparam logic [3:0] BYTE_BITS     = 4'h8;
	localparam logic [3:0] LAST_TX_BIT   = 4'h7;
	localparam logic [1:0] IDX_MS        = 2'h0;
	localparam logic [1:0] IDX_LS        = 2'h1;
	localparam logic [1:0] IDX_CRC       = 2'h2;
	localparam int         CLK_PERIOD_NS = 10;
	localparam int         CONV_TIME_NS  = 1000;
	localparam int         CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		L_IDLE = 4'h0, L_ADDR = 4'h1, L_ACK = 4'h2, L_RX = 4'h3,
		L_TX = 4'h4, L_TXACK = 4'h5, L_STRETCH = 4'h6, L_IGNORE = 4'h7
	} link_st_e;
	typedef enum logic [1:0] {
		RD_NONE = 2'h0, RD_MEAS = 2'h1, RD_PREV = 2'h2, RD_UREG = 2'h3
	} rd_kind_e;
	typedef struct packed {
		logic [15:0] word;
		logic [15:0] temp;
	} meas_res_s;
	typedef struct packed {
		logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, dn_s1, dn_s2, dn_d;
		link_st_e    st;
		logic [3:0]  bcnt;
		logic [7:0]  sh;
		logic        rw, first, wr_pend, quit, busy, hold, is_hum, mack;
		rd_kind_e    rd;
		logic [1:0]  idx;
		logic [15:0] res;
		logic [15:0] prev;
		logic [7:0]  ureg;
		logic        req_tgl, abort_tgl, sda_oe, scl_oe;
	} link_s;
	typedef struct packed {
		logic        rq_s1, rq_s2, rq_d, ab_s1, ab_s2, ab_d;
		logic        busy, hum, done_tgl;
		logic [15:0] cnt;
		meas_res_s   res;
	} core_s;
endpackage : rht_cmd_pkg

// ==== rtl/rht_cmd_unit.sv ====
// i2c target command unit of the humidity/temperature sensor
// Behaviour
// - answer only to 7-bit address 0x40, read/write bit as byte lsb
// - 0xe5 starts humidity with clock stretch, 0xf5 humidity with read refusal
// - 0xe3 starts temperature with clock stretch, 0xf3 temperature with refusal
// - 0xe0 returns temperature from last humidity conversion, no new conversion
// - 0xfe is soft reset, 0xe6 writes, 0xe7 reads the user register
// - stretch mode holds scl low after read address until conversion ends
// - refusal mode nacks read address while converting; host retries
// - host ack of low result byte brings one checksum byte
// - host nack of low result byte then stop: bus released, no checksum
// - checksum is crc-8, polynomial x^8+x^5+x^4+1, start value zero
// - checksum only after the four measurement commands
// - results are 16-bit words sent high byte first
// - humidity result low two bits read 10
// - each humidity conversion also captures and stores a temperature
// - previous temperature read answers at once with high then low byte
// - temperature result low two bits read 00
`timescale 1ns/1ps
module rht_cmd_unit
	import rht_cmd_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYC
)(
	input  wire logic        clk_in,         // core clock, 100 MHz
	input  wire logic        sys_rst_in,     // async reset, active high
	input  wire logic        link_clk_in,    // link-side sampling clock
	input  wire logic        scl_in,         // scl pin level
	output logic             scl_out,        // scl drive level, always low
	output logic             scl_oe_out,     // high while stretching scl
	input  wire logic        sda_in,         // sda pin level
	output logic             sda_out,        // sda drive level, always low
	output logic             sda_oe_out,     // high while pulling sda low
	input  wire logic [15:0] hum_sample_in,  // humidity value from front end
	input  wire logic [15:0] temp_sample_in, // temperature value from front end
	output logic             conv_busy_out,  // conversion running
	output logic             heater_en_out   // heater enable from user register
);
	link_s     l, ln;
	core_s     c, cn;
	logic      lrst_s1, lrst_s2;
	logic      lrst;
	logic      rise, fall, start, stop, dn_edge;
	logic      rq_edge, ab_edge;
	logic      drv_r;
	logic      more;
	logic [7:0] nxt_byte;
	logic [7:0] first_byte;

	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] r;
		r = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			r = (r[7] ^ w[i]) ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction : crc8

	function automatic logic [7:0] pick_byte(input rd_kind_e k, input logic [1:0] i,
			input logic [15:0] res, input logic [15:0] prev, input logic [7:0] ureg);
		logic [7:0] b;
		b = 8'hff;
		case (k)
			RD_MEAS: b = (i == IDX_MS) ? res[15:8] : (i == IDX_LS) ? res[7:0] : crc8(res);
			RD_PREV: b = (i == IDX_MS) ? prev[15:8] : prev[7:0];
			RD_UREG: b = ureg;
			default: b = 8'hff;
		endcase
		return b;
	endfunction : pick_byte

	// link reset leaves on the link clock so no flop sees a release mid-edge
	always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			lrst_s1 <= 1'b1;
			lrst_s2 <= 1'b1;
		end else begin
			lrst_s1 <= 1'b0;
			lrst_s2 <= lrst_s1;
		end
	end
	assign lrst = lrst_s2;

	assign rise     = l.scl_s2 & ~l.scl_d;
	assign fall     = ~l.scl_s2 & l.scl_d;
	assign start    = l.scl_s2 & l.scl_d & l.sda_d & ~l.sda_s2;
	assign stop     = l.scl_s2 & l.scl_d & ~l.sda_d & l.sda_s2;
	assign dn_edge  = l.dn_s2 ^ l.dn_d;
	assign first_byte = pick_byte(l.rd, IDX_MS, l.res, l.prev, l.ureg);
	assign nxt_byte = pick_byte(l.rd, 2'(l.idx + 2'h1), l.res, l.prev, l.ureg);
	assign more     = (l.rd == RD_MEAS && l.idx < IDX_CRC) || (l.rd == RD_PREV && l.idx < IDX_LS);

	always_comb begin
		ln        = l;
		ln.scl_s1 = scl_in;
		ln.scl_s2 = l.scl_s1;
		ln.scl_d  = l.scl_s2;
		ln.sda_s1 = sda_in;
		ln.sda_s2 = l.sda_s1;
		ln.sda_d  = l.sda_s2;
		ln.dn_s1  = c.done_tgl;
		ln.dn_s2  = l.dn_s1;
		ln.dn_d   = l.dn_s2;
		// result words stay frozen in the core until the next conversion ends
		if (dn_edge) begin
			ln.prev = c.res.temp;
			if (l.busy) begin
				ln.busy = 1'b0;
				ln.res  = c.res.word;
			end
		end
		case (l.st)
			L_ADDR, L_RX: begin
				if (rise && l.bcnt < BYTE_BITS) begin
					ln.sh   = {l.sh[6:0], l.sda_s2};
					ln.bcnt = l.bcnt + 4'h1;
				end else if (fall && l.bcnt == BYTE_BITS) begin
					ln.st     = L_ACK;
					ln.sda_oe = 1'b1;
					if (l.st == L_ADDR) begin
						ln.rw      = l.sh[0];
						ln.first   = ~l.sh[0];
						ln.wr_pend = 1'b0;
						ln.quit    = 1'b0;
						if (l.sh[7:1] != DEV_ADDR) begin
							ln.st     = L_IGNORE;
							ln.sda_oe = 1'b0;
						end else if (l.sh[0] && l.rd == RD_MEAS && l.busy && !l.hold) begin
							ln.st     = L_IGNORE;
							ln.sda_oe = 1'b0;
						end
					end else if (l.first) begin
						ln.first = 1'b0;
						case (l.sh)
							CMD_HUM_HOLD, CMD_HUM_POLL, CMD_TMP_HOLD, CMD_TMP_POLL: begin
								ln.busy    = 1'b1;
								ln.is_hum  = (l.sh == CMD_HUM_HOLD) || (l.sh == CMD_HUM_POLL);
								ln.hold    = (l.sh == CMD_HUM_HOLD) || (l.sh == CMD_TMP_HOLD);
								ln.rd      = RD_MEAS;
								ln.req_tgl = ~l.req_tgl;
							end
							CMD_PREV_TMP: ln.rd = RD_PREV;
							CMD_UREG_RD:  ln.rd = RD_UREG;
							CMD_UREG_WR: begin
								ln.rd      = RD_NONE;
								ln.wr_pend = 1'b1;
							end
							CMD_SOFT_RST: begin
								ln.busy      = 1'b0;
								ln.abort_tgl = ~l.abort_tgl;
								ln.ureg      = UREG_RESET;
								ln.rd        = RD_NONE;
								ln.quit      = 1'b1;
							end
							default: ln.rd = RD_NONE;
						endcase
					end else if (l.wr_pend) begin
						ln.wr_pend = 1'b0;
						ln.ureg    = (l.ureg & ~UREG_WMASK) | (l.sh & UREG_WMASK);
					end
				end
			end
			L_ACK: begin
				if (fall) begin
					ln.sda_oe = 1'b0;
					ln.bcnt   = 4'h0;
					ln.idx    = IDX_MS;
					ln.mack   = 1'b0;
					if (l.quit) begin
						ln.st = L_IGNORE;
					end else if (!l.rw) begin
						ln.st = L_RX;
					end else if (l.rd == RD_MEAS && l.busy) begin
						ln.st     = L_STRETCH;
						ln.scl_oe = 1'b1;
					end else begin
						ln.st     = L_TX;
						ln.sh     = first_byte;
						ln.sda_oe = ~first_byte[7];
					end
				end
			end
			L_STRETCH: begin
				// mack marks the first bit as set up one cycle before scl is let go
				if (!l.busy) begin
					if (!l.mack) begin
						ln.mack   = 1'b1;
						ln.sh     = first_byte;
						ln.sda_oe = ~first_byte[7];
					end else begin
						ln.mack   = 1'b0;
						ln.scl_oe = 1'b0;
						ln.st     = L_TX;
					end
				end
			end
			L_TX: begin
				if (fall) begin
					if (l.bcnt == LAST_TX_BIT) begin
						ln.sda_oe = 1'b0;
						ln.st     = L_TXACK;
					end else begin
						ln.sh     = {l.sh[6:0], 1'b0};
						ln.sda_oe = ~l.sh[6];
						ln.bcnt   = l.bcnt + 4'h1;
					end
				end
			end
			L_TXACK: begin
				if (rise) begin
					ln.mack = ~l.sda_s2;
				end else if (fall) begin
					if (l.mack && more) begin
						ln.idx    = 2'(l.idx + 2'h1);
						ln.sh     = nxt_byte;
						ln.sda_oe = ~nxt_byte[7];
						ln.bcnt   = 4'h0;
						ln.st     = L_TX;
					end else begin
						ln.st = L_IGNORE;
					end
				end
			end
			default: ln.st = l.st;
		endcase
		if (start) begin
			ln.st     = L_ADDR;
			ln.bcnt   = 4'h0;
			ln.sda_oe = 1'b0;
		end else if (stop) begin
			ln.st     = L_IDLE;
			ln.sda_oe = 1'b0;
		end
	end

	always_ff @(posedge link_clk_in or posedge lrst) begin
		if (lrst) begin
			l      <= '0;
			l.ureg <= UREG_RESET;
			l.scl_s1 <= 1'b1;
			l.scl_s2 <= 1'b1;
			l.scl_d  <= 1'b1;
			l.sda_s1 <= 1'b1;
			l.sda_s2 <= 1'b1;
			l.sda_d  <= 1'b1;
		end else begin
			l <= ln;
		end
	end

	// core side: conversion timer and result capture
	assign rq_edge = c.rq_s2 ^ c.rq_d;
	assign ab_edge = c.ab_s2 ^ c.ab_d;
	always_comb begin
		cn       = c;
		cn.rq_s1 = l.req_tgl;
		cn.rq_s2 = c.rq_s1;
		cn.rq_d  = c.rq_s2;
		cn.ab_s1 = l.abort_tgl;
		cn.ab_s2 = c.ab_s1;
		cn.ab_d  = c.ab_s2;
		if (ab_edge) begin
			cn.busy = 1'b0;
		end
		// is_hum is steady in the link domain once the request toggle has crossed
		if (rq_edge) begin
			cn.busy = 1'b1;
			cn.hum  = l.is_hum;
			cn.cnt  = 16'h0;
		end else if (c.busy && !ab_edge) begin
			if (c.cnt == 16'(CONV_CYCLES - 1)) begin
				cn.busy     = 1'b0;
				cn.done_tgl = ~c.done_tgl;
				if (c.hum) begin
					cn.res.word = {hum_sample_in[15:2], HUM_TAIL};
					cn.res.temp = {temp_sample_in[15:2], TEMP_TAIL};
				end else begin
					cn.res.word = {temp_sample_in[15:2], TEMP_TAIL};
				end
			end else begin
				cn.cnt = c.cnt + 16'h1;
			end
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			c <= '0;
		end else begin
			c <= cn;
		end
	end
	always_ff @(posedge link_clk_in or posedge lrst) begin
		if (lrst) begin
			drv_r <= 1'b0;
		end else begin
			drv_r <= 1'b0;
		end
	end
	assign scl_out       = drv_r;
	assign sda_out       = drv_r;
	assign scl_oe_out    = l.scl_oe;
	assign sda_oe_out    = l.sda_oe;
	assign conv_busy_out = c.busy;
	assign heater_en_out = l.ureg[UREG_HEAT_BIT];

	sequence s_addr_done;
		l.st == L_ADDR && fall && l.bcnt == BYTE_BITS;
	endsequence
	sequence s_cmd_done;
		l.st == L_RX && fall && l.bcnt == BYTE_BITS && l.first;
	endsequence
	sequence s_last_nack;
		l.st == L_TXACK && fall && !l.mack;
	endsequence

	a_addr_mismatch: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_addr_done ##0 (l.sh[7:1] != DEV_ADDR) |=> l.st == L_IGNORE && !l.sda_oe)
		else $error("foreign address acknowledged");
	a_hum_start: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_cmd_done ##0 (l.sh == CMD_HUM_HOLD || l.sh == CMD_HUM_POLL)
		|=> l.busy && l.is_hum && l.req_tgl != $past(l.req_tgl))
		else $error("humidity command did not start conversion");
	a_tmp_start: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_cmd_done ##0 (l.sh == CMD_TMP_HOLD) |=> l.busy && !l.is_hum && l.hold)
		else $error("temperature hold command mishandled");
	a_prev_nostart: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_cmd_done ##0 (l.sh == CMD_PREV_TMP) |=> l.rd == RD_PREV && $stable(l.req_tgl))
		else $error("previous temperature read started a conversion");
	a_soft_reset: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_cmd_done ##0 (l.sh == CMD_SOFT_RST)
		|=> l.ureg == UREG_RESET && !l.busy && l.abort_tgl != $past(l.abort_tgl))
		else $error("soft reset incomplete");
	a_stretch_hold: assert property (@(posedge link_clk_in) disable iff (lrst)
		(l.st == L_STRETCH && l.busy) |-> l.scl_oe)
		else $error("scl released while converting");
	a_poll_refuse: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_addr_done ##0 (l.sh == {DEV_ADDR, 1'b1} && l.rd == RD_MEAS && l.busy && !l.hold)
		|=> !l.sda_oe [*2])
		else $error("read acknowledged during conversion");
	a_crc_follow: assert property (@(posedge link_clk_in) disable iff (lrst)
		(l.st == L_TXACK && fall && l.mack && l.rd == RD_MEAS && l.idx == IDX_LS)
		|=> l.st == L_TX && l.sh == crc8(l.res))
		else $error("checksum byte not sent");
	a_nack_release: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_last_nack |=> l.st == L_IGNORE && !l.sda_oe)
		else $error("bus kept after host nack");
	a_no_crc_other: assert property (@(posedge link_clk_in) disable iff (lrst)
		(l.st == L_TX && l.rd != RD_MEAS) |-> l.idx < IDX_CRC)
		else $error("checksum sent for non-measurement command");
	a_prev_immediate: assert property (@(posedge link_clk_in) disable iff (lrst)
		(l.st == L_ACK && fall && l.rw && l.rd == RD_PREV && !l.quit)
		|=> l.st == L_TX && !l.scl_oe && l.sh == l.prev[15:8])
		else $error("previous temperature not answered at once");
	a_hum_tail: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		($changed(c.done_tgl) && c.hum) |-> c.res.word[1:0] == HUM_TAIL)
		else $error("humidity result tail wrong");
	a_tmp_tail: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		($changed(c.done_tgl) && !c.hum) |-> c.res.word[1:0] == TEMP_TAIL)
		else $error("temperature result tail wrong");
	a_hum_temp: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		($changed(c.done_tgl) && c.hum)
		|-> c.res.temp[15:2] == $past(temp_sample_in[15:2], 1))
		else $error("humidity conversion lost its temperature");
endmodule : rht_cmd_unit

// ==== bench/i2c_host_model.sv ====
// host-side i2c controller model for the sensor command unit
`timescale 1ns/1ps
module i2c_host_model (
	input  wire logic clk_in,    // bit timing clock
	input  wire logic scl_in,    // resolved scl wire
	input  wire logic sda_in,    // resolved sda wire
	output logic      scl_out,   // 0 pulls scl low
	output logic      sda_out,   // 0 pulls sda low
	output logic      res_v_out, // one-cycle result strobe
	output logic [8:0] res_out   // bit 8 set: ack slot
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
		res_v_out = 1'b0;
		res_out = 9'h000;
	end
	task automatic half();
		repeat (10) @(posedge clk_in);
	endtask : half
	task automatic report(input logic [8:0] v);
		res_out <= v;
		res_v_out <= 1'b1;
		@(posedge clk_in);
		res_v_out <= 1'b0;
	endtask : report
	// sda moves well after scl falls so it is never mistaken for start or stop
	task automatic bit_io(input logic b, output logic r);
		int n;
		n = 0;
		repeat (4) @(posedge clk_in);
		sda_out <= b;
		half();
		scl_out <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (scl_in !== 1'b1 && n < 20000);
		half();
		r = sda_in;
		scl_out <= 1'b0;
	endtask : bit_io
	task automatic start();
		repeat (4) @(posedge clk_in);
		sda_out <= 1'b1;
		half();
		scl_out <= 1'b1;
		half();
		sda_out <= 1'b0;
		half();
		scl_out <= 1'b0;
	endtask : start
	task automatic stop();
		repeat (4) @(posedge clk_in);
		sda_out <= 1'b0;
		half();
		scl_out <= 1'b1;
		half();
		sda_out <= 1'b1;
		half();
	endtask : stop
	task automatic wr_byte(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		report({8'h80, r});
	endtask : wr_byte
	task automatic rd_byte(input logic a);
		logic [7:0] d;
		logic       r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(a, r);
		report({1'b0, d});
	endtask : rd_byte
endmodule : i2c_host_model

// ==== bench/rht_cmd_unit_tb.sv ====
// self-checking bench of the sensor command unit
`timescale 1ns/1ps
module rht_cmd_unit_tb;
	import rht_cmd_pkg::*;
	localparam int         CONV = 1000;
	localparam logic [8:0] ACK  = 9'h100;
	localparam logic [8:0] NAK  = 9'h101;
	logic        clk_in     = 1'b0;
	logic        link_clk   = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic [15:0] hum_s      = 16'h0000;
	logic [15:0] tmp_s      = 16'h0000;
	logic        scl_d, scl_oe, sda_d, sda_oe, busy, heat, h_scl, h_sda, res_v;
	logic [8:0]  res;
	logic [8:0]  expq[$];
	// humidity first, so the later temperature runs must leave the stored value alone
	logic [7:0]  cmds[4]    = '{CMD_HUM_HOLD, CMD_HUM_POLL, CMD_TMP_HOLD, CMD_TMP_POLL};
	logic [7:0]  c;
	logic [15:0] w, prev;
	int          fails       = 0;
	int          comparisons = 0;
	int          n;
	wire         scl_w = (scl_oe ? scl_d : 1'b1) & h_scl;
	wire         sda_w = (sda_oe ? sda_d : 1'b1) & h_sda;
	always #5 clk_in = ~clk_in;
	initial begin
		#3.3;
		forever #6 link_clk = ~link_clk;
	end
	rht_cmd_unit #(.CONV_CYCLES(CONV)) i_dut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link_clk_in(link_clk),
		.scl_in(scl_w), .scl_out(scl_d), .scl_oe_out(scl_oe),
		.sda_in(sda_w), .sda_out(sda_d), .sda_oe_out(sda_oe),
		.hum_sample_in(hum_s), .temp_sample_in(tmp_s),
		.conv_busy_out(busy), .heater_en_out(heat));
	i2c_host_model i_host (
		.clk_in(clk_in), .scl_in(scl_w), .sda_in(sda_w), .scl_out(h_scl),
		.sda_out(h_sda), .res_v_out(res_v), .res_out(res));
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] r;
		r = CRC_INIT;
		for (int i = 15; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? CRC_POLY : 8'h00);
		return r;
	endfunction : crc8
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	// levels are taken at the falling clock edge, away from the edge that moves them, except the check right after stop
	task automatic check_level(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check_level
	task automatic final_report();
		if (fails == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	task automatic wb(input logic [7:0] b, input logic [8:0] e);
		expq.push_back(e);
		i_host.wr_byte(b);
	endtask : wb
	task automatic rb(input logic a, input logic [7:0] e);
		expq.push_back({1'b0, e});
		i_host.rd_byte(a);
	endtask : rb
	task automatic hdr(input logic [7:0] cm);
		i_host.start();
		wb({DEV_ADDR, 1'b0}, ACK);
		wb(cm, ACK);
	endtask : hdr
	task automatic ureg_rd(input logic [7:0] e);
		hdr(CMD_UREG_RD);
		i_host.start();
		wb({DEV_ADDR, 1'b1}, ACK);
		rb(1'b1, e);
		i_host.stop();
	endtask : ureg_rd
	// a result with no note waiting is forced to mismatch
	always @(posedge clk_in) begin
		if (res_v === 1'b1) begin
			check(res, (expq.size() > 0) ? expq.pop_front() : ~res);
		end
	end
	initial begin
		repeat (50000) @(posedge clk_in);
		fails++;
		final_report();
	end
	initial begin
		void'($urandom(83));
		repeat (6) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		i_host.start();
		wb({7'h41, 1'b0}, NAK);
		i_host.stop();
		for (int k = 0; k < 4; k++) begin
			c = cmds[k];
			@(posedge clk_in);
			// full-range codes: readings beyond 0 to 100 percent are legal and compared raw
			hum_s <= 16'($urandom());
			tmp_s <= 16'($urandom());
			@(posedge clk_in);
			w = c[2] ? {hum_s[15:2], HUM_TAIL} : {tmp_s[15:2], TEMP_TAIL};
			if (c[2]) prev = {tmp_s[15:2], TEMP_TAIL};
			hdr(c);
			i_host.start();
			if (c[4]) begin
				wb({DEV_ADDR, 1'b1}, NAK);
				n = 0;
				while (busy !== 1'b0 && n < 2000) begin
					@(posedge clk_in);
					n++;
				end
				repeat (20) @(posedge clk_in);
				i_host.start();
			end
			wb({DEV_ADDR, 1'b1}, ACK);
			repeat (10) @(negedge clk_in);
			check_level(busy, !c[4]);
			check_level(scl_oe, !c[4]);
			check_level(scl_d | sda_d, 1'b0);
			rb(1'b0, w[15:8]);
			rb(k[0], w[7:0]);
			if (!k[0]) rb(1'b1, crc8(w));
			// a checksum after the nack would pull sda here, before stop resets the link
			repeat (10) @(negedge clk_in);
			check_level(sda_oe, 1'b0);
			i_host.stop();
			check_level(sda_oe, 1'b0);
		end
		hdr(CMD_PREV_TMP);
		tmp_s <= ~tmp_s;
		i_host.start();
		wb({DEV_ADDR, 1'b1}, ACK);
		rb(1'b0, prev[15:8]);
		rb(1'b1, prev[7:0]);
		i_host.stop();
		@(negedge clk_in);
		check_level(busy, 1'b0);
		hdr(CMD_UREG_WR);
		wb(8'hff, ACK);
		i_host.stop();
		@(negedge clk_in);
		check_level(heat, 1'b1);
		ureg_rd(((UREG_RESET & ~UREG_WMASK) | UREG_WMASK) & 8'hbf);
		hdr(CMD_HUM_POLL);
		i_host.stop();
		@(negedge clk_in);
		check_level(busy, 1'b1);
		hdr(CMD_SOFT_RST);
		i_host.stop();
		repeat (20) @(negedge clk_in);
		check_level(busy, 1'b0);
		check_level(heat, 1'b0);
		ureg_rd(UREG_RESET & 8'hbf);
		repeat (20) @(posedge clk_in);
		if (expq.size() != 0) fails++;
		final_report();
	end
endmodule : rht_cmd_unit_tb
